// [design/metering_readback_register_bank.sv]
// Metering readback and mode register bank behind the serial port
// Contract
// - Each access starts with a command byte; bit 7 write, bits 6..0 address.
// - Three signed 16-bit read-only apparent energy accumulators, one per phase.
// - Formula setting low two bits choose how apparent energy is formed.
// - Signed 24-bit current RMS for phases A-C; a mode bit picks the source.
// - Signed 24-bit voltage RMS for phases A-C at consecutive addresses.
// - Twelve-bit line rate reports frequency, or period when bit 7 is set.
// - Measurement select low two bits choose the phase for line rate.
// - Thermal reading always holds the latest temperature conversion.
// - Waveform register samples a selected input or power; bits 0-4 select.
// - General operation config is 8-bit read/write, reset value 4.
// - Measurement channel select is 8-bit read/write, reset value 0xfc.
// - Waveform capture config is 8-bit read/write, reset value zero.
`timescale 1ns/1ps
`default_nettype none
module metering_readback_register_bank
	import meter_regs_pkg::*;
#(
	parameter int GATE_LEN = GATE_CYCLES,
	parameter int TICK_DIV = PERIOD_DIV
) (
	// Clock and reset
	input wire logic MCLK,
	input wire logic SRST,
	// Serial port pins
	input wire logic CS_N,
	input wire logic SCLK,
	input wire logic DIN,
	output logic DOUT,
	output logic DOUT_OE,
	// Settings held outside this bank
	input wire logic [7:0] ENERGY_FORMULA_CONFIG,
	input wire logic [7:0] LINE_CYCLE_ACCUMULATION_CONFIG,
	// Energy feed
	input wire logic ENERGY_STROBE,
	input wire logic [15:0] PHASE_C_REACTIVE_INCR,
	// RMS feed, phase A in the low 24 bits
	input wire logic RMS_STROBE,
	input wire logic [71:0] IRMS_PRIMARY,
	input wire logic [71:0] IRMS_ALTERNATE,
	input wire logic [71:0] VRMS,
	// Temperature feed
	input wire logic TEMP_DONE,
	input wire logic [7:0] TEMP_VALUE,
	// Zero crossings of the three voltages
	input wire logic [2:0] ZERO_CROSS,
	// Waveform feed, phase A in the low 24 bits
	input wire logic WAVE_STROBE,
	input wire logic [71:0] WAVE_CURRENT,
	input wire logic [71:0] WAVE_VOLTAGE,
	input wire logic [71:0] WAVE_POWER,
	// Mode register contents
	output logic [7:0] GENERAL_OPERATION_CONFIG,
	output logic [7:0] MEASUREMENT_CHANNEL_SELECT,
	output logic [7:0] WAVEFORM_CAPTURE_CONFIG
);
	logic cmd_valid;
	logic [6:0] addr;
	logic wr_valid;
	logic [23:0] wr_data;
	logic [23:0] rd_word;
	logic [1:0] xfer_bytes;
	logic [7:0] gen_cfg_r;
	logic [7:0] meas_sel_r;
	logic [7:0] wave_cfg_r;
	logic [15:0] reactive_c_r;
	logic [15:0] energy_r [3];
	logic [15:0] incr [3];
	logic [23:0] irms_r [3];
	logic [23:0] vrms_r [3];
	logic [23:0] irms_src [3];
	logic [11:0] line_rate;
	logic [7:0] temp_r;
	logic [23:0] wave_r;
	logic [23:0] wave_src;
	logic [2:0] wave_div_r;
	logic [2:0] wave_mask;
	logic wave_take;
	logic [1:0] formula;
	logic [1:0] wave_phase;
	logic [2:0] wave_kind;

	// Serial front end
	serial_port u_port (
		.clk(MCLK),
		.rst(SRST),
		.cs_n(CS_N),
		.sclk(SCLK),
		.din(DIN),
		.dout_r(DOUT),
		.dout_oe_r(DOUT_OE),
		.xfer_bytes(xfer_bytes),
		.rd_word(rd_word),
		.cmd_valid_r(cmd_valid),
		.addr_r(addr),
		.wr_valid_r(wr_valid),
		.wr_data_r(wr_data)
	);

	// Line rate engine
	line_rate_meter #(
		.GATE_LEN(GATE_LEN),
		.TICK_DIV(TICK_DIV)
	) u_rate (
		.clk(MCLK),
		.rst(SRST),
		.zx(ZERO_CROSS),
		.sel(meas_sel_r[ZX_SEL_LSB +: 2]),
		.period_mode(LINE_CYCLE_ACCUMULATION_CONFIG[LINE_PERIOD_BIT]),
		.reading_r(line_rate)
	);

	assign GENERAL_OPERATION_CONFIG = gen_cfg_r;
	assign MEASUREMENT_CHANNEL_SELECT = meas_sel_r;
	assign WAVEFORM_CAPTURE_CONFIG = wave_cfg_r;
	assign formula = ENERGY_FORMULA_CONFIG[FORMULA_LSB +: 2];

	// Mode registers; only these three accept writes
	always_ff @(posedge MCLK) begin
		if (SRST) begin
			gen_cfg_r <= RST_GENERAL_OPERATION_CONFIG;
			meas_sel_r <= RST_MEASUREMENT_CHANNEL_SELECT;
			wave_cfg_r <= RST_WAVEFORM_CAPTURE_CONFIG;
		end else if (wr_valid) begin
			case (addr)
				ADDR_GENERAL_OPERATION_CONFIG: gen_cfg_r <= wr_data[7:0];
				ADDR_MEASUREMENT_CHANNEL_SELECT: meas_sel_r <= wr_data[7:0];
				ADDR_WAVEFORM_CAPTURE_CONFIG: wave_cfg_r <= wr_data[7:0];
				default: ;
			endcase
		end
	end

	// Per-phase energy, current and voltage results
	for (genvar p = 0; p < 3; p++) begin : g_phase
		logic [11:0] v_mag;
		logic [11:0] i_mag;
		logic [23:0] prod;
		assign v_mag = (formula == 2'd1) ? VRMS[22:11] : (formula == 2'd2) ? 12'hfff
			: VRMS[24 * p + 11 +: 12];
		assign i_mag = IRMS_PRIMARY[24 * p + 11 +: 12];
		assign prod = v_mag * i_mag;
		assign incr[p] = {8'h00, prod[ENERGY_INCR_LSB +: 8]};
		assign irms_src[p] = gen_cfg_r[CUR_SRC_BIT] ? IRMS_ALTERNATE[24 * p +: 24]
			: IRMS_PRIMARY[24 * p +: 24];

		always_ff @(posedge MCLK) begin
			if (SRST) begin
				energy_r[p] <= RST_RESULT[15:0];
			end else if (ENERGY_STROBE) begin
				energy_r[p] <= energy_r[p] + incr[p];
			end
		end

		always_ff @(posedge MCLK) begin
			if (SRST) begin
				irms_r[p] <= RST_RESULT;
				vrms_r[p] <= RST_RESULT;
			end else if (RMS_STROBE) begin
				irms_r[p] <= irms_src[p];
				vrms_r[p] <= VRMS[24 * p +: 24];
			end
		end
	end

	// Reactive energy of phase C
	always_ff @(posedge MCLK) begin
		if (SRST) begin
			reactive_c_r <= RST_RESULT[15:0];
		end else if (ENERGY_STROBE) begin
			reactive_c_r <= reactive_c_r + PHASE_C_REACTIVE_INCR;
		end
	end

	always_ff @(posedge MCLK) begin
		if (SRST) begin
			temp_r <= RST_RESULT[7:0];
		end else if (TEMP_DONE) begin
			temp_r <= TEMP_VALUE;
		end
	end

	// Waveform source and decimation
	assign wave_phase = wave_cfg_r[WAVE_PHASE_LSB +: 2];
	assign wave_kind = wave_cfg_r[WAVE_KIND_LSB +: 3];
	assign wave_mask = 3'((4'h1 << wave_cfg_r[WAVE_RATE_LSB +: 2]) - 4'h1);
	assign wave_take = WAVE_STROBE && ((wave_div_r & wave_mask) == 3'd0);

	always_comb begin
		logic [71:0] bank;
		bank = (wave_kind == 3'd0) ? WAVE_CURRENT : (wave_kind == 3'd1) ? WAVE_VOLTAGE : WAVE_POWER;
		case (wave_phase)
			2'd1: wave_src = bank[47:24];
			2'd2: wave_src = bank[71:48];
			default: wave_src = bank[23:0];
		endcase
	end

	always_ff @(posedge MCLK) begin
		if (SRST) begin
			wave_div_r <= 3'd0;
			wave_r <= RST_RESULT;
		end else if (WAVE_STROBE) begin
			wave_div_r <= wave_div_r + 3'd1;
			if (wave_take) begin
				wave_r <= wave_src;
			end
		end
	end

	// Readback multiplexer and transfer length
	always_comb begin
		rd_word = 24'h000000;
		xfer_bytes = 2'd1;
		case (addr)
			ADDR_PHASE_C_REACTIVE_ENERGY: begin
				rd_word = {8'h00, reactive_c_r};
				xfer_bytes = 2'd2;
			end
			ADDR_PHASE_A_APPARENT_ENERGY, ADDR_PHASE_B_APPARENT_ENERGY,
			ADDR_PHASE_C_APPARENT_ENERGY: begin
				rd_word = {8'h00, energy_r[2'(addr - ADDR_PHASE_A_APPARENT_ENERGY)]};
				xfer_bytes = 2'd2;
			end
			ADDR_PHASE_A_CURRENT_RMS, ADDR_PHASE_B_CURRENT_RMS, ADDR_PHASE_C_CURRENT_RMS: begin
				rd_word = irms_r[2'(addr - ADDR_PHASE_A_CURRENT_RMS)];
				xfer_bytes = 2'd3;
			end
			ADDR_PHASE_A_VOLTAGE_RMS, ADDR_PHASE_B_VOLTAGE_RMS, ADDR_PHASE_C_VOLTAGE_RMS: begin
				rd_word = vrms_r[2'(addr - ADDR_PHASE_A_VOLTAGE_RMS)];
				xfer_bytes = 2'd3;
			end
			ADDR_LINE_RATE_READING: begin
				rd_word = {12'h000, line_rate};
				xfer_bytes = 2'd2;
			end
			ADDR_THERMAL_READING: rd_word = {16'h0000, temp_r};
			ADDR_SAMPLED_WAVEFORM: begin
				rd_word = wave_r;
				xfer_bytes = 2'd3;
			end
			ADDR_GENERAL_OPERATION_CONFIG: rd_word = {16'h0000, gen_cfg_r};
			ADDR_MEASUREMENT_CHANNEL_SELECT: rd_word = {16'h0000, meas_sel_r};
			ADDR_WAVEFORM_CAPTURE_CONFIG: rd_word = {16'h0000, wave_cfg_r};
			default: ;
		endcase
	end

	property p_reset_values;
		@(posedge MCLK) (!SRST && $past(SRST)) |-> gen_cfg_r == RST_GENERAL_OPERATION_CONFIG
			&& meas_sel_r == RST_MEASUREMENT_CHANNEL_SELECT
			&& wave_cfg_r == RST_WAVEFORM_CAPTURE_CONFIG;
	endproperty
	a_reset_values: assert property (p_reset_values) else $error("bad mode reset");

	property p_gen_write;
		@(posedge MCLK) disable iff (SRST)
		(wr_valid && addr == ADDR_GENERAL_OPERATION_CONFIG) |=> gen_cfg_r == $past(wr_data[7:0]);
	endproperty
	a_gen_write: assert property (p_gen_write) else $error("general config write lost");

	property p_meas_write;
		@(posedge MCLK) disable iff (SRST)
		(wr_valid && addr == ADDR_MEASUREMENT_CHANNEL_SELECT) |=> meas_sel_r == $past(wr_data[7:0])
			&& $stable(gen_cfg_r) && $stable(wave_cfg_r);
	endproperty
	a_meas_write: assert property (p_meas_write) else $error("measurement select write wrong");

	property p_wave_write;
		@(posedge MCLK) disable iff (SRST)
		(wr_valid && addr == ADDR_WAVEFORM_CAPTURE_CONFIG) |=> wave_cfg_r == $past(wr_data[7:0]);
	endproperty
	a_wave_write: assert property (p_wave_write) else $error("waveform config write lost");

	property p_ro_ignored;
		@(posedge MCLK) disable iff (SRST)
		(wr_valid && addr >= ADDR_PHASE_A_CURRENT_RMS && addr <= ADDR_PHASE_C_VOLTAGE_RMS
			&& !RMS_STROBE) |=> $stable(irms_r[0]) && $stable(vrms_r[2]) && $stable(gen_cfg_r);
	endproperty
	a_ro_ignored: assert property (p_ro_ignored) else $error("read-only result changed");

	property p_energy_step;
		@(posedge MCLK) disable iff (SRST)
		ENERGY_STROBE |=> energy_r[1] == 16'($past(energy_r[1]) + $past(incr[1]));
	endproperty
	a_energy_step: assert property (p_energy_step) else $error("energy step wrong");

	property p_formula_full;
		@(posedge MCLK) disable iff (SRST)
		(formula == 2'd2) |-> incr[0] == {8'h00, 8'(({12'h000, 12'hfff} * IRMS_PRIMARY[22:11]) >> 16)};
	endproperty
	a_formula_full: assert property (p_formula_full) else $error("formula operands wrong");

	property p_irms_source;
		@(posedge MCLK) disable iff (SRST)
		(RMS_STROBE && gen_cfg_r[CUR_SRC_BIT]) |=> irms_r[1] == $past(IRMS_ALTERNATE[47:24]);
	endproperty
	a_irms_source: assert property (p_irms_source) else $error("current source wrong");

	property p_vrms_capture;
		@(posedge MCLK) disable iff (SRST)
		RMS_STROBE |=> vrms_r[2] == $past(VRMS[71:48]) ##1 ($past(RMS_STROBE) || $stable(vrms_r[2]));
	endproperty
	a_vrms_capture: assert property (p_vrms_capture) else $error("voltage rms wrong");

	property p_temp_latest;
		@(posedge MCLK) disable iff (SRST)
		TEMP_DONE |=> temp_r == $past(TEMP_VALUE);
	endproperty
	a_temp_latest: assert property (p_temp_latest) else $error("temperature not latest");

	property p_wave_sample;
		@(posedge MCLK) disable iff (SRST)
		wave_take |=> wave_r == $past(wave_src);
	endproperty
	a_wave_sample: assert property (p_wave_sample) else $error("waveform sample wrong");

	c_read_rms: cover property (@(posedge MCLK) disable iff (SRST)
		cmd_valid && addr == ADDR_PHASE_B_VOLTAGE_RMS);
	c_ro_write: cover property (@(posedge MCLK) disable iff (SRST)
		wr_valid && addr == ADDR_THERMAL_READING);
	c_wave_decim: cover property (@(posedge MCLK) disable iff (SRST)
		WAVE_STROBE && !wave_take);
endmodule : metering_readback_register_bank
`default_nettype wire

// [design/meter_regs_pkg.sv]
// Register map, field layout, reset values and timing of the readback bank
package meter_regs_pkg;
	// Register addresses
	localparam logic [6:0] ADDR_PHASE_C_REACTIVE_ENERGY = 7'h06;
	localparam logic [6:0] ADDR_PHASE_A_APPARENT_ENERGY = 7'h07;
	localparam logic [6:0] ADDR_PHASE_B_APPARENT_ENERGY = 7'h08;
	localparam logic [6:0] ADDR_PHASE_C_APPARENT_ENERGY = 7'h09;
	localparam logic [6:0] ADDR_PHASE_A_CURRENT_RMS = 7'h0a;
	localparam logic [6:0] ADDR_PHASE_B_CURRENT_RMS = 7'h0b;
	localparam logic [6:0] ADDR_PHASE_C_CURRENT_RMS = 7'h0c;
	localparam logic [6:0] ADDR_PHASE_A_VOLTAGE_RMS = 7'h0d;
	localparam logic [6:0] ADDR_PHASE_B_VOLTAGE_RMS = 7'h0e;
	localparam logic [6:0] ADDR_PHASE_C_VOLTAGE_RMS = 7'h0f;
	localparam logic [6:0] ADDR_LINE_RATE_READING = 7'h10;
	localparam logic [6:0] ADDR_THERMAL_READING = 7'h11;
	localparam logic [6:0] ADDR_SAMPLED_WAVEFORM = 7'h12;
	localparam logic [6:0] ADDR_GENERAL_OPERATION_CONFIG = 7'h13;
	localparam logic [6:0] ADDR_MEASUREMENT_CHANNEL_SELECT = 7'h14;
	localparam logic [6:0] ADDR_WAVEFORM_CAPTURE_CONFIG = 7'h15;
	// Reset values
	localparam logic [7:0] RST_GENERAL_OPERATION_CONFIG = 8'h04;
	localparam logic [7:0] RST_MEASUREMENT_CHANNEL_SELECT = 8'hfc;
	localparam logic [7:0] RST_WAVEFORM_CAPTURE_CONFIG = 8'h00;
	localparam logic [23:0] RST_RESULT = 24'h000000;
	// Field positions
	localparam int CMD_WRITE_BIT = 7;
	localparam int CUR_SRC_BIT = 0;
	localparam int FORMULA_LSB = 0;
	localparam int LINE_PERIOD_BIT = 7;
	localparam int ZX_SEL_LSB = 0;
	localparam int WAVE_PHASE_LSB = 0;
	localparam int WAVE_KIND_LSB = 2;
	localparam int WAVE_RATE_LSB = 5;
	localparam int ENERGY_INCR_LSB = 16;
	// Timing
	localparam int CLK_PERIOD_NS = 10;
	localparam int GATE_TIME_MS = 1000;
	localparam int GATE_CYCLES = GATE_TIME_MS * 1000000 / CLK_PERIOD_NS;
	localparam int PERIOD_TICK_NS = 4000;
	localparam int PERIOD_DIV = PERIOD_TICK_NS / CLK_PERIOD_NS;
	// Serial port states
	typedef enum logic [1:0] {
		SP_CMD = 2'b00,
		SP_DATA = 2'b01,
		SP_HOLD = 2'b10
	} sp_state_e;
endpackage : meter_regs_pkg

// [design/serial_port.sv]
// Serial register port: command byte then register data
`timescale 1ns/1ps
`default_nettype none
module serial_port
	import meter_regs_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Pins
	input wire logic cs_n,
	input wire logic sclk,
	input wire logic din,
	output logic dout_r,
	output logic dout_oe_r,
	// Register side
	input wire logic [1:0] xfer_bytes,
	input wire logic [23:0] rd_word,
	output logic cmd_valid_r,
	output logic [6:0] addr_r,
	output logic wr_valid_r,
	output logic [23:0] wr_data_r
);
	sp_state_e state_r;
	logic sclk_q_r;
	logic is_write_r;
	logic [4:0] bit_cnt_r;
	logic [23:0] rx_r;
	logic [23:0] tx_r;
	logic fall;
	logic rise;
	logic [4:0] last_bit;

	// Edge detection on the serial clock
	assign fall = sclk_q_r & ~sclk & ~cs_n;
	assign rise = ~sclk_q_r & sclk & ~cs_n;
	assign last_bit = {xfer_bytes, 3'b000} - 5'd1;

	always_ff @(posedge clk) begin
		sclk_q_r <= rst ? 1'b1 : sclk;
	end

	// Frame sequencer, input bits taken on falling edges
	always_ff @(posedge clk) begin
		if (rst || cs_n) begin
			state_r <= SP_CMD;
			bit_cnt_r <= 5'd0;
			is_write_r <= 1'b0;
			rx_r <= 24'h000000;
			addr_r <= 7'h00;
		end else if (fall) begin
			rx_r <= {rx_r[22:0], din};
			bit_cnt_r <= bit_cnt_r + 5'd1;
			case (state_r)
				SP_CMD: begin
					if (bit_cnt_r == 5'd7) begin
						state_r <= SP_DATA;
						bit_cnt_r <= 5'd0;
						addr_r <= {rx_r[5:0], din};
						is_write_r <= rx_r[CMD_WRITE_BIT - 1];
					end
				end
				SP_DATA: begin
					if (bit_cnt_r == last_bit) begin
						state_r <= SP_HOLD;
					end
				end
				default: begin
					state_r <= SP_HOLD;
				end
			endcase
		end
	end

	// One-cycle strobes for command and write data
	always_ff @(posedge clk) begin
		cmd_valid_r <= !rst && state_r == SP_CMD && fall && bit_cnt_r == 5'd7;
		wr_valid_r <= !rst && state_r == SP_DATA && fall && bit_cnt_r == last_bit && is_write_r;
		wr_data_r <= rst ? 24'h000000 : {rx_r[22:0], din};
	end

	// Whole register snapshot, shifted out on rising edges
	always_ff @(posedge clk) begin
		if (rst || cs_n) begin
			tx_r <= 24'h000000;
			dout_r <= 1'b0;
		end else if (cmd_valid_r) begin
			tx_r <= rd_word << {2'd3 - xfer_bytes, 3'b000};
		end else if (rise && state_r != SP_CMD && !is_write_r) begin
			dout_r <= tx_r[23];
			tx_r <= {tx_r[22:0], 1'b0};
		end
	end

	// Drive the data pin only during a read data phase
	always_ff @(posedge clk) begin
		dout_oe_r <= !rst && !cs_n && state_r != SP_CMD && !is_write_r;
	end

	property p_cmd_direction;
		@(posedge clk) disable iff (rst)
		(state_r == SP_CMD && fall && bit_cnt_r == 5'd7 && !cs_n) |=> (is_write_r == $past(rx_r[6]))
			&& cmd_valid_r && (addr_r == $past({rx_r[5:0], din}));
	endproperty
	a_cmd_direction: assert property (p_cmd_direction) else $error("command byte misdecoded");

	c_write_done: cover property (@(posedge clk) disable iff (rst) wr_valid_r);
endmodule : serial_port
`default_nettype wire

// [design/line_rate_meter.sv]
// Line frequency or period from zero crossings of one selected phase
`timescale 1ns/1ps
`default_nettype none
module line_rate_meter
	import meter_regs_pkg::*;
#(
	parameter int GATE_LEN = GATE_CYCLES,
	parameter int TICK_DIV = PERIOD_DIV
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Crossings and settings
	input wire logic [2:0] zx,
	input wire logic [1:0] sel,
	input wire logic period_mode,
	// Result
	output logic [11:0] reading_r
);
	logic zx_sel;
	logic zx_q_r;
	logic edge_zx;
	logic [31:0] gate_cnt_r;
	logic [31:0] tick_cnt_r;
	logic [11:0] per_cnt_r;
	logic [11:0] zx_cnt_r;
	logic gate_end;
	logic tick;

	assign zx_sel = (sel == 2'd1) ? zx[1] : (sel == 2'd2) ? zx[2] : zx[0];
	assign edge_zx = zx_sel & ~zx_q_r;
	assign gate_end = gate_cnt_r == 32'(GATE_LEN - 1);
	assign tick = tick_cnt_r == 32'(TICK_DIV - 1);

	// Timebases
	always_ff @(posedge clk) begin
		zx_q_r <= rst ? 1'b0 : zx_sel;
		gate_cnt_r <= (rst || gate_end) ? 32'd0 : gate_cnt_r + 32'd1;
		tick_cnt_r <= (rst || tick) ? 32'd0 : tick_cnt_r + 32'd1;
	end

	// Saturating period and crossing counters
	always_ff @(posedge clk) begin
		if (rst || edge_zx) begin
			per_cnt_r <= 12'h000;
		end else if (tick && per_cnt_r != 12'hfff) begin
			per_cnt_r <= per_cnt_r + 12'h001;
		end
		if (rst || gate_end) begin
			zx_cnt_r <= {11'h000, edge_zx && !rst};
		end else if (edge_zx && zx_cnt_r != 12'hfff) begin
			zx_cnt_r <= zx_cnt_r + 12'h001;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			reading_r <= 12'h000;
		end else if (period_mode && edge_zx) begin
			reading_r <= per_cnt_r;
		end else if (!period_mode && gate_end) begin
			reading_r <= zx_cnt_r;
		end
	end

	property p_period_capture;
		@(posedge clk) disable iff (rst)
		(period_mode && edge_zx) |=> reading_r == $past(per_cnt_r);
	endproperty
	a_period_capture: assert property (p_period_capture) else $error("period not captured");

	property p_line_rate_reading_capture;
		@(posedge clk) disable iff (rst)
		(!period_mode && gate_end) |=> reading_r == $past(zx_cnt_r);
	endproperty
	a_line_rate_reading_capture: assert property (p_line_rate_reading_capture) else $error("frequency not captured");

	property p_phase_select;
		@(posedge clk) disable iff (rst)
		(sel == 2'd1 && $stable(sel) && zx[1] && !$past(zx[1])) |-> edge_zx;
	endproperty
	a_phase_select: assert property (p_phase_select) else $error("wrong phase drives rate");

	c_period: cover property (@(posedge clk) disable iff (rst) period_mode && edge_zx);
endmodule : line_rate_meter
`default_nettype wire

// [dv/serial_host.sv]
// Host model that runs command and data frames on the serial pins
`timescale 1ns/1ps
`default_nettype none
module serial_host (
	// Clock
	input wire logic clk,
	// Serial pins
	output logic cs_n,
	output logic sclk,
	output logic din,
	input wire logic dout,
	input wire logic dout_oe
);
	// Idle: deselected, clock high
	initial begin
		cs_n = 1'b1;
		sclk = 1'b1;
		din = 1'b0;
	end

	// One bit: data set while high, taken at the fall
	task automatic shift_bit(input logic b, output logic r);
		din = b;
		repeat (3) @(posedge clk);
		// Undriven line reads inverted so a late enable shows up
		#1 r = dout_oe ? dout : ~dout;
		sclk = 1'b0;
		repeat (3) @(posedge clk);
		#1 sclk = 1'b1;
	endtask : shift_bit

	// command byte, then data, MSB first
	task automatic frame(input logic [7:0] cmd, input int nbytes, input logic [23:0] wdata,
			output logic [23:0] rdata);
		logic r;
		rdata = 24'h000000;
		cs_n = 1'b0;
		for (int i = 7; i >= 0; i--) begin
			shift_bit(cmd[i], r);
		end
		for (int i = 8 * nbytes - 1; i >= 0; i--) begin
			shift_bit(wdata[i], r);
			rdata = {rdata[22:0], r};
		end
		repeat (3) @(posedge clk);
		#1 cs_n = 1'b1;
		din = ~din; // No stale value once released
		// Gap keeps a read clear of the last write byte
		repeat (120) @(posedge clk);
		#1;
	endtask : frame
endmodule : serial_host
`default_nettype wire

// [dv/metering_readback_register_bank_tb.sv]
// Self-checking bench for the metering readback register bank
`timescale 1ns/1ps
`default_nettype none
module metering_readback_register_bank_tb;
	import meter_regs_pkg::*;
	typedef struct {logic [6:0] addr; int nbytes; logic [23:0] exp;} row_s;
	logic mclk = 1'b0, srst = 1'b1, cs_n, sclk, din, dout, dout_oe;
	logic [7:0] formula = 8'h00, lcyc = 8'h00, temp_value = 8'h00;
	logic [7:0] op_cfg, meas_sel, wave_cfg;
	logic energy_strobe = 1'b0, rms_strobe = 1'b0, temp_done = 1'b0, wave_strobe = 1'b0;
	logic [15:0] react_incr = 16'h0123;
	logic [71:0] irms_p = {24'h3c0c3c, 24'h2b0b2b, 24'h400000};
	logic [71:0] irms_a = {24'h3d1d3d, 24'h2e1e2e, 24'h1f1f1f};
	logic [71:0] vrms = {24'h5d5d5d, 24'h4e4e4e, 24'h400000};
	logic [71:0] wave_i = {24'hc1c1c1, 24'hb1b1b1, 24'ha1a1a1};
	logic [71:0] wave_v = {24'hc2c2c2, 24'hb2b2b2, 24'ha2a2a2};
	logic [71:0] wave_p = {24'hc3c3c3, 24'hb3b3b3, 24'ha3a3a3};
	logic [23:0] wexp[3] = '{24'hb1b1b1, 24'hb2b2b2, 24'hb3b3b3};
	logic [2:0] zero_cross = 3'h0;
	int error_cnt = 0;
	int n_compared = 0;
	// Reset contents of every register, plus one unmapped address
	row_s rows[17] = '{'{7'h06, 2, 0}, '{7'h07, 2, 0}, '{7'h08, 2, 0}, '{7'h09, 2, 0},
		'{7'h0a, 3, 0}, '{7'h0b, 3, 0}, '{7'h0c, 3, 0}, '{7'h0d, 3, 0}, '{7'h0e, 3, 0},
		'{7'h0f, 3, 0}, '{7'h10, 2, 0}, '{7'h11, 1, 0}, '{7'h12, 3, 0}, '{7'h13, 1, 24'h04},
		'{7'h14, 1, 24'hfc}, '{7'h15, 1, 0}, '{7'h7f, 1, 0}};

	metering_readback_register_bank #(.GATE_LEN(200), .TICK_DIV(4))
			metering_readback_register_bank_i (
		.MCLK(mclk), .SRST(srst), .CS_N(cs_n), .SCLK(sclk), .DIN(din), .DOUT(dout),
		.DOUT_OE(dout_oe), .ENERGY_FORMULA_CONFIG(formula),
		.LINE_CYCLE_ACCUMULATION_CONFIG(lcyc), .ENERGY_STROBE(energy_strobe),
		.PHASE_C_REACTIVE_INCR(react_incr), .RMS_STROBE(rms_strobe),
		.IRMS_PRIMARY(irms_p), .IRMS_ALTERNATE(irms_a), .VRMS(vrms),
		.TEMP_DONE(temp_done), .TEMP_VALUE(temp_value), .ZERO_CROSS(zero_cross),
		.WAVE_STROBE(wave_strobe), .WAVE_CURRENT(wave_i), .WAVE_VOLTAGE(wave_v),
		.WAVE_POWER(wave_p), .GENERAL_OPERATION_CONFIG(op_cfg),
		.MEASUREMENT_CHANNEL_SELECT(meas_sel), .WAVEFORM_CAPTURE_CONFIG(wave_cfg));

	serial_host serial_host_i (.clk(mclk), .cs_n(cs_n), .sclk(sclk), .din(din), .dout(dout),
		.dout_oe(dout_oe));

	// Clock
	always #5 mclk = ~mclk;

	// Phase B crossings, one rise every 40 cycles
	always begin
		repeat (20) @(posedge mclk);
		#1 zero_cross[1] = ~zero_cross[1];
	end

	task automatic tick(input int n);
		repeat (n) @(posedge mclk);
		#1;
	endtask : tick

	task automatic pulse(ref logic s, input int n);
		s = 1'b1;
		tick(n);
		s = 1'b0;
		tick(1);
	endtask : pulse

	task automatic compare(input string what, input logic [23:0] exp, input logic [23:0] got);
		n_compared++;
		if (got !== exp) begin
			error_cnt++;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask : compare

	task automatic chk_reg(input logic [6:0] a, input int n, input logic [23:0] exp);
		logic [23:0] got;
		serial_host_i.frame({1'b0, a}, n, 24'h000000, got);
		compare($sformatf("register %h", a), exp, got);
	endtask : chk_reg

	task automatic wr(input logic [6:0] a, input int n, input logic [23:0] d);
		logic [23:0] junk;
		serial_host_i.frame({1'b1, a}, n, d, junk);
	endtask : wr

	task automatic end_of_test();
		$display("Comparisons %0d errors %0d", n_compared, error_cnt);
		if (error_cnt == 0 && n_compared > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask : end_of_test

	// Watchdog against a hung frame
	initial begin
		repeat (60000) @(posedge mclk);
		error_cnt++;
		$display("Error watchdog expected end seen timeout");
		end_of_test();
	end

	// Main sequence
	initial begin
		tick(8);
		srst = 1'b0;
		tick(2);
		foreach (rows[i]) begin
			chk_reg(rows[i].addr, rows[i].nbytes, rows[i].exp);
		end
		wr(ADDR_GENERAL_OPERATION_CONFIG, 1, 24'ha6);
		wr(ADDR_MEASUREMENT_CHANNEL_SELECT, 1, 24'h29);
		wr(ADDR_WAVEFORM_CAPTURE_CONFIG, 1, 24'h5a);
		compare("general config port", 24'ha6, {16'h0000, op_cfg});
		compare("meas select port", 24'h29, {16'h0000, meas_sel});
		compare("wave config port", 24'h5a, {16'h0000, wave_cfg});
		compare("oe after write", 24'h0, {23'h0, dout_oe});
		chk_reg(ADDR_MEASUREMENT_CHANNEL_SELECT, 1, 24'h29);
		chk_reg(ADDR_WAVEFORM_CAPTURE_CONFIG, 1, 24'h5a);
		// Results capture and accumulate
		pulse(rms_strobe, 1);
		pulse(energy_strobe, 2);
		formula = 8'h02;
		pulse(energy_strobe, 1);
		chk_reg(ADDR_PHASE_C_REACTIVE_ENERGY, 2, 24'h0369);
		chk_reg(ADDR_PHASE_A_APPARENT_ENERGY, 2, 24'h00ff);
		// Phase B: two own-voltage steps, one full-scale, one with phase A voltage
		formula = 8'h01;
		pulse(energy_strobe, 1);
		chk_reg(ADDR_PHASE_B_APPARENT_ENERGY, 2, 24'h00e9);
		for (int i = 0; i < 3; i++) begin
			chk_reg(ADDR_PHASE_A_CURRENT_RMS + 7'(i), 3, irms_p[24 * i +: 24]);
			chk_reg(ADDR_PHASE_A_VOLTAGE_RMS + 7'(i), 3, vrms[24 * i +: 24]);
		end
		wr(ADDR_GENERAL_OPERATION_CONFIG, 1, 24'h05);
		pulse(rms_strobe, 1);
		chk_reg(ADDR_PHASE_B_CURRENT_RMS, 3, irms_a[47:24]);
		wr(ADDR_PHASE_A_VOLTAGE_RMS, 3, 24'h123456);
		chk_reg(ADDR_PHASE_A_VOLTAGE_RMS, 3, vrms[23:0]);
		// Later conversion replaces the earlier one
		temp_value = 8'h9c;
		pulse(temp_done, 1);
		temp_value = 8'h21;
		pulse(temp_done, 1);
		chk_reg(ADDR_THERMAL_READING, 1, 24'h21);
		// Phase B current, voltage and power samples
		for (int k = 0; k < 3; k++) begin
			wr(ADDR_WAVEFORM_CAPTURE_CONFIG, 1, {16'h0000, 3'b000, 3'(k), 2'b01});
			pulse(wave_strobe, 1);
			chk_reg(ADDR_SAMPLED_WAVEFORM, 3, wexp[k]);
		end
		// One strobe in two kept: fourth strobe since reset skipped, fifth taken
		wr(ADDR_WAVEFORM_CAPTURE_CONFIG, 1, 24'h000024);
		pulse(wave_strobe, 1);
		chk_reg(ADDR_SAMPLED_WAVEFORM, 3, wexp[2]);
		pulse(wave_strobe, 1);
		chk_reg(ADDR_SAMPLED_WAVEFORM, 3, wave_v[23:0]);
		// Phase B selected: five rises per gate, ten ticks per cycle
		chk_reg(ADDR_LINE_RATE_READING, 2, 24'h0005);
		lcyc = 8'h80;
		tick(100);
		chk_reg(ADDR_LINE_RATE_READING, 2, 24'h000a);
		// Mid-run reset restores mode registers and clears results
		pulse(srst, 2);
		compare("general config after reset", 24'h04, {16'h0000, op_cfg});
		chk_reg(ADDR_MEASUREMENT_CHANNEL_SELECT, 1, 24'hfc);
		chk_reg(ADDR_THERMAL_READING, 1, 24'h00);
		end_of_test();
	end
endmodule : metering_readback_register_bank_tb
`default_nettype wire
